// >>> logic/idl_loop_gen.v
// Supply-current measurement loop pattern generator for a DDR3 part
//
// What this block does
// - Cycle 0 of sub-loop 0 issues activate with bank, address, termination zero.
// - Cycles 1 and 2 drive deselect with strobe lines low.
// - Cycles 3 and 4 drive deselect with all strobe lines high.
// - Pad with deselect group, precharge at row-active count.
// - Pad to row-cycle count, then second activate with address 6..3 ones.
// - Second half commands carry address 6..3 ones, precharge at nRC+nRAS.
// - Eight sub-loops of twice nRC, bank equals sub-loop number.
// - Data mask held low throughout both loops.
// - Strobe pair left undriven during activate-precharge loop.
// - Data lines left undriven during activate-precharge loop.
// - Read loop issues read at nRCD, expected data all zeros.
// - Second half read at nRC+nRCD, pattern 00110011, address 6..3 ones.
// - Strobe pair moves only for reads, otherwise undriven.
// - Data lines undriven when no read burst is running.
// - Burst length eight required: mode register 0 bits 1..0 zero.
// - Nibble sequential burst type: mode register 0 bit 3 zero.
`timescale 1ns/1ps
`include "idl_consts.vh"
module idl_loop_gen (
  // Clock, reset, enable
  input  wire                      i_sys_clk,
  input  wire                      i_nrst,
  input  wire                      i_ce,
  // Control from the tester side
  input  wire                      i_start,
  input  wire                      i_stop,
  input  wire                      i_read_loop,
  input  wire [`IDL_CNT_W-1:0]     i_nras,
  input  wire [`IDL_CNT_W-1:0]     i_nrc,
  input  wire [`IDL_CNT_W-1:0]     i_nrcd,
  input  wire [1:0]                i_mr0_bl,
  input  wire                      i_mr0_bt,
  // Status
  output reg                       o_busy,
  output reg                       o_cfg_err,
  output reg  [`IDL_SUB_W-1:0]     o_sub_loop,
  output reg                       o_rd_issue,
  output reg  [`IDL_DQ_W-1:0]      o_exp_data,
  // Pin-side observation of the data strobe from the memory
  input  wire                      i_dqs_pin,
  output wire                      o_dqs_seen,
  // Memory command pins
  output wire                      o_cke,
  output reg                       o_cs_n,
  output reg                       o_ras_n,
  output reg                       o_cas_n,
  output reg                       o_we_n,
  output reg                       o_odt,
  output reg  [`IDL_BA_W-1:0]      o_ba,
  output reg  [`IDL_ADDR_W-1:0]    o_addr,
  output reg                       o_dm,
  // Two-way data strobe and data, output enable low while driving
  output wire                      o_dqs_out,
  output wire                      o_dqs_oe_n,
  output wire [`IDL_DQ_W-1:0]      o_dq_out,
  output wire                      o_dq_oe_n
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RUN  = 3'h2;
  localparam [2:0] ST_ERR  = 3'h4;

  reg  [2:0]             state;
  reg  [2:0]             next_state;
  reg  [`IDL_CNT_W:0]    cyc;
  reg  [`IDL_CNT_W-1:0]  nras;
  reg  [`IDL_CNT_W-1:0]  nrc;
  reg  [`IDL_CNT_W-1:0]  nrcd;
  reg                    rd_mode;

  // Decoded pattern for the current cycle
  wire                   second_half;
  wire [`IDL_CNT_W:0]    nrc_w;
  wire [`IDL_CNT_W:0]    sub_len;
  wire [`IDL_CNT_W:0]    half_pos;
  wire [1:0]             grp_pos;
  wire                   is_act;
  wire                   is_pre;
  wire                   is_rd;
  wire                   is_dlow;
  wire                   enc_cs_n;
  wire                   enc_ras_n;
  wire                   enc_cas_n;
  wire                   enc_we_n;
  wire                   cfg_ok;

  assign nrc_w       = {1'b0, nrc};
  assign sub_len     = {nrc, 1'b0};
  assign second_half = (cyc >= nrc_w);
  assign half_pos    = second_half ? (cyc - nrc_w) : cyc;
  assign grp_pos     = half_pos[1:0] & `IDL_GRP_MASK;
  // Position within each half picks the command
  assign is_act  = (half_pos == {1'b0, `IDL_ZERO_CNT});
  assign is_pre  = (half_pos == {1'b0, nras});
  assign is_rd   = rd_mode && (half_pos == {1'b0, nrcd});
  // Deselect group repeats 1,2 low-type then 3,4 high-type
  assign is_dlow = (grp_pos == `IDL_GRP_LOW0) || (grp_pos == `IDL_GRP_LOW1);
  // Mode register 0 must give burst of eight and nibble order
  assign cfg_ok  = (i_mr0_bl == `IDL_MR0_BL8) && (i_mr0_bt == `IDL_MR0_NIBBLE);

  idl_cmd_enc u_enc (
    .i_act   (is_act),
    .i_pre   (is_pre),
    .i_rd    (is_rd),
    .i_dlow  (is_dlow),
    .o_cs_n  (enc_cs_n),
    .o_ras_n (enc_ras_n),
    .o_cas_n (enc_cas_n),
    .o_we_n  (enc_we_n)
  );

  idl_sync2 u_dqs_sync (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_d       (i_dqs_pin),
    .o_q       (o_dqs_seen)
  );

  // ****************************************************************
  // Control state machine
  // ****************************************************************
  // Next state from start, stop and configuration check
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (i_start) begin
          next_state = cfg_ok ? ST_RUN : ST_ERR;
        end
      end
      ST_RUN: begin
        if (i_stop) begin
          next_state = ST_IDLE;
        end
      end
      ST_ERR: begin
        if (!i_start) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State, timing capture and loop counters
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state      <= ST_IDLE;
      cyc        <= {(`IDL_CNT_W+1){1'b0}};
      nras       <= `IDL_NRAS_DEF;
      nrc        <= `IDL_NRC_DEF;
      nrcd       <= `IDL_NRCD_DEF;
      rd_mode    <= 1'b0;
      o_sub_loop <= {`IDL_SUB_W{1'b0}};
      o_cfg_err  <= 1'b0;
    end else if (i_ce) begin
      state <= next_state;
      if (state == ST_IDLE && i_start) begin
        // Timing and loop kind are latched at start
        nras       <= i_nras;
        nrc        <= i_nrc;
        nrcd       <= i_nrcd;
        rd_mode    <= i_read_loop;
        cyc        <= {(`IDL_CNT_W+1){1'b0}};
        o_sub_loop <= {`IDL_SUB_W{1'b0}};
        o_cfg_err  <= !cfg_ok;
      end else if (state == ST_RUN) begin
        if (cyc == sub_len - {1'b0, `IDL_ONE_CNT}) begin
          // Sub-loop ends after twice nRC; wraps after the eighth
          cyc        <= {(`IDL_CNT_W+1){1'b0}};
          o_sub_loop <= o_sub_loop + 3'h1;
        end else begin
          cyc <= cyc + {1'b0, `IDL_ONE_CNT};
        end
      end
    end
  end

  // ****************************************************************
  // Pin outputs, registered
  // ****************************************************************
  // Command pins follow the decoded pattern while running, else high deselect
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cs_n     <= 1'b1;
      o_ras_n    <= 1'b1;
      o_cas_n    <= 1'b1;
      o_we_n     <= 1'b1;
      o_odt      <= 1'b0;
      o_ba       <= {`IDL_BA_W{1'b0}};
      o_addr     <= {`IDL_ADDR_W{1'b0}};
      o_dm       <= 1'b0;
      o_busy     <= 1'b0;
      o_rd_issue <= 1'b0;
      o_exp_data <= `IDL_RD_PAT0;
    end else if (i_ce) begin
      o_dm   <= 1'b0;
      o_odt  <= 1'b0;
      o_busy <= (state == ST_RUN);
      if (state == ST_RUN) begin
        o_cs_n  <= enc_cs_n;
        o_ras_n <= enc_ras_n;
        o_cas_n <= enc_cas_n;
        o_we_n  <= enc_we_n;
        o_ba    <= o_sub_loop;
        o_addr  <= {`IDL_ADDR_W{1'b0}};
        if (second_half) begin
          o_addr[`IDL_A_FIELD_HI:`IDL_A_FIELD_LO] <= `IDL_A_FIELD_ON;
        end
        o_rd_issue <= is_rd;
        if (is_rd) begin
          o_exp_data <= second_half ? `IDL_RD_PAT1 : `IDL_RD_PAT0;
        end
      end else begin
        o_cs_n     <= 1'b1;
        o_ras_n    <= 1'b1;
        o_cas_n    <= 1'b1;
        o_we_n     <= 1'b1;
        o_rd_issue <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Clock enable and two-way pins
  // ****************************************************************
  assign o_cke      = 1'b1;
  // The host never drives strobe or data; the memory drives them on reads
  assign o_dqs_out  = 1'b0;
  assign o_dqs_oe_n = 1'b1;
  assign o_dq_out   = {`IDL_DQ_W{1'b0}};
  assign o_dq_oe_n  = 1'b1;

endmodule

// >>> include/idl_consts.vh
// Constants for the supply-current loop pattern generator
`ifndef IDL_CONSTS_VH
`define IDL_CONSTS_VH
// Loop counter and pin bus widths
`define IDL_CNT_W      8
`define IDL_SUB_W      3
`define IDL_BA_W       3
`define IDL_ADDR_W     15
`define IDL_DQ_W       8
// Default row timing counts in clock cycles
`define IDL_NRAS_DEF   8'h0F
`define IDL_NRC_DEF    8'h15
`define IDL_NRCD_DEF   8'h05
// Deselect group shape: offsets within the four-cycle group
`define IDL_GRP_MASK   2'h3
`define IDL_GRP_LOW0   2'h1
`define IDL_GRP_LOW1   2'h2
// Address field positions
`define IDL_A_FIELD_LO 3
`define IDL_A_FIELD_HI 6
`define IDL_A_FIELD_ON 4'hF
// Mode register 0 settings checked before a run
`define IDL_MR0_BL8    2'h0
`define IDL_MR0_NIBBLE 1'h0
// Expected read data patterns, then counter and sub-loop constants
`define IDL_RD_PAT0    8'h00
`define IDL_RD_PAT1    8'h33
`define IDL_ZERO_CNT   8'h00
`define IDL_ONE_CNT    8'h01
`define IDL_LAST_SUB   3'h7
`endif

// >>> logic/idl_sync2.v
// Two-stage synchroniser for one pin-side level
`timescale 1ns/1ps
module idl_sync2 (
  // Clock and reset
  input  wire i_sys_clk,
  input  wire i_nrst,
  input  wire i_ce,
  // Level in and out
  input  wire i_d,
  output wire o_q
);
  reg s1;
  reg s2;
  // Only the second stage is read outside
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
    end else if (i_ce) begin
      s1 <= i_d;
      s2 <= s1;
    end
  end
  assign o_q = s2;
endmodule

// >>> logic/idl_cmd_enc.v
// Command encoder: command kind to strobe levels
`timescale 1ns/1ps
module idl_cmd_enc (
  // Command kind; low deselect can be set together with precharge or read
  input  wire i_act,
  input  wire i_pre,
  input  wire i_rd,
  input  wire i_dlow,
  // Strobe levels
  output reg  o_cs_n,
  output reg  o_ras_n,
  output reg  o_cas_n,
  output reg  o_we_n
);
  // Priority decides: activate, then precharge, then read, then low deselect, which can coincide with precharge or read
  always @* begin
    if (i_act) begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h3;
    end else if (i_pre) begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h2;
    end else if (i_rd) begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h5;
    end else if (i_dlow) begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h8;
    end else begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
    end
  end
endmodule

// >>> sim/idl_loop_monitor.sv
// Checker for the loop pattern generator pins
`timescale 1ns/1ps
`include "idl_consts.vh"
module idl_loop_monitor (
  // Clock and control
  input wire                   i_sys_clk,
  input wire                   i_nrst,
  input wire                   i_start,
  input wire                   i_stop,
  input wire [1:0]             i_mr0_bl,
  input wire                   i_mr0_bt,
  // Status
  input wire                   o_busy,
  input wire                   o_cfg_err,
  input wire                   o_rd_issue,
  input wire [`IDL_DQ_W-1:0]   o_exp_data,
  // Memory pins
  input wire                   o_cke,
  input wire                   o_cs_n,
  input wire                   o_ras_n,
  input wire                   o_cas_n,
  input wire                   o_we_n,
  input wire                   o_odt,
  input wire [`IDL_BA_W-1:0]   o_ba,
  input wire [`IDL_ADDR_W-1:0] o_addr,
  input wire                   o_dm,
  input wire                   o_dqs_oe_n,
  input wire                   o_dq_oe_n
);
  // Command decode of the strobe lines
  wire [3:0] cmd = {o_cs_n, o_ras_n, o_cas_n, o_we_n};
  wire       lo  = (cmd == 4'h8);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  chk_pins_quiet: assert property (o_cke && !o_dm && !o_odt)
    else $error("cke dm odt wrong");
  chk_dq_float: assert property (o_dq_oe_n)
    else $error("data driven");
  chk_dqs_float: assert property (o_dqs_oe_n)
    else $error("strobe driven");
  chk_first_act: assert property (!o_busy && $rose(i_start) && !i_stop
    && i_mr0_bl == 2'h0 && !i_mr0_bt |=> ##1 cmd == 4'h3 && o_ba == 0 && o_addr == 0 && o_busy)
    else $error("first activate");
  chk_cfg_refuse: assert property (!o_busy && $rose(i_start)
    && (i_mr0_bl != 2'h0 || i_mr0_bt) |=> o_cfg_err && !o_busy ##1 !o_busy)
    else $error("bad mode accepted");
  chk_low_pair: assert property (o_busy && cmd == 4'h3 && !i_stop |=> lo || o_rd_issue)
    else $error("no low deselect");
  chk_high_after: assert property (lo && $past(lo) && !i_stop |=> !o_cs_n || cmd == 4'hF)
    else $error("no high deselect");
  chk_bank_step: assert property (o_busy && $past(o_busy) && o_ba != $past(o_ba)
    |-> cmd == 4'h3 && o_addr[6:3] == 4'h0)
    else $error("bank moved off loop start");
  chk_read_data: assert property (o_rd_issue |-> cmd == 4'h5
    && o_exp_data == (o_addr[6:3] == 4'hF ? 8'h33 : 8'h00))
    else $error("read flag or data");
endmodule
bind idl_loop_gen idl_loop_monitor mon_u (
  .i_sys_clk, .i_nrst, .i_start, .i_stop, .i_mr0_bl, .i_mr0_bt, .o_busy, .o_cfg_err,
  .o_rd_issue, .o_exp_data, .o_cke, .o_cs_n, .o_ras_n, .o_cas_n, .o_we_n, .o_odt,
  .o_ba, .o_addr, .o_dm, .o_dqs_oe_n, .o_dq_oe_n
);

// >>> sim/idl_mem_model.sv
// Memory side model: answers read commands on the data strobe
`timescale 1ns/1ps
module idl_mem_model #(
  parameter int RD_LAT = 5
) (
  input  wire       i_sys_clk,
  input  wire       i_nrst,
  input  wire [3:0] i_cmd,
  output reg        o_dqs
);
  reg [15:0] rd_pipe;
  // Strobe toggles only during a burst and otherwise rests, never unknown
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_pipe <= 16'h0000;
      o_dqs   <= 1'b0;
    end else begin
      rd_pipe <= {rd_pipe[14:0], i_cmd == 4'h5};
      if (|rd_pipe[RD_LAT+3:RD_LAT]) o_dqs <= ~o_dqs;
    end
  end
endmodule

// >>> sim/idl_loop_gen_tb_top.sv
// Testbench for the loop pattern generator
`timescale 1ns/1ps
`include "idl_consts.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", n, e, s); end end
module idl_loop_gen_tb_top;
  localparam int NRC = 12, NRAS = 9, NRCD = 6;
  reg        i_sys_clk, i_nrst, i_ce, i_start, i_stop, i_read_loop, i_mr0_bt;
  reg  [1:0] i_mr0_bl;
  reg  [7:0] i_nras, i_nrc, i_nrcd;
  wire       busy, cfg_err, rd_issue, cke, cs_n, ras_n, cas_n, we_n, odt, dm, dqs;
  wire       dqs_seen, dqs_out, dqs_oe_n, dq_oe_n;
  wire [2:0] sub, ba;
  wire [7:0] exp_data, dq_out;
  wire [14:0] addr;
  int        err_total, tests_run;
  idl_loop_gen dut_u (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_start(i_start), .i_stop(i_stop), .i_read_loop(i_read_loop), .i_nras(i_nras),
    .i_nrc(i_nrc), .i_nrcd(i_nrcd), .i_mr0_bl(i_mr0_bl), .i_mr0_bt(i_mr0_bt),
    .o_busy(busy), .o_cfg_err(cfg_err), .o_sub_loop(sub), .o_rd_issue(rd_issue),
    .o_exp_data(exp_data), .i_dqs_pin(dqs), .o_dqs_seen(dqs_seen), .o_cke(cke), .o_cs_n(cs_n),
    .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_odt(odt), .o_ba(ba),
    .o_addr(addr), .o_dm(dm), .o_dqs_out(dqs_out), .o_dqs_oe_n(dqs_oe_n), .o_dq_out(dq_out),
    .o_dq_oe_n(dq_oe_n));
  idl_mem_model mem_u (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_cmd({cs_n, ras_n, cas_n, we_n}), .o_dqs(dqs));
  // ****************
  // Clock and tasks
  // ****************
  initial begin
    i_sys_clk = 0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Wrong mode bits refuse the run, then the start must drop
  task automatic t_cfg;
    for (int k = 0; k < 2; k++) begin
      i_mr0_bl = k ? 2'h0 : 2'h1;
      i_mr0_bt = k;
      i_start = 1;
      @(negedge i_sys_clk);
      `CHK("cfg err", 2'b10, {cfg_err, busy})
      @(negedge i_sys_clk);
      `CHK("cfg pins", 4'hF, {cs_n, ras_n, cas_n, we_n})
      i_start = 0;
      @(negedge i_sys_clk);
    end
    i_mr0_bl = 2'h0;
    i_mr0_bt = 0;
    $display("t_cfg done");
  endtask
  // Full eight sub-loops plus the wrap, compared cycle by cycle, then stop
  task automatic t_run(input bit rd);
    logic [3:0] c;
    logic [2:0] b;
    logic [2:0] sb;
    logic       ds;
    int p, h;
    i_read_loop = rd;
    i_start = 1;
    @(negedge i_sys_clk);
    i_start = 0;
    // Cycle 0 of the pattern stands on the pins at this first falling edge
    for (int k = 0; k < 16 * NRC + 3; k++) begin
      @(negedge i_sys_clk);
      p = k % NRC;
      h = (k / NRC) % 2;
      b = 3'((k / (2 * NRC)) % 8);
      // Sub-loop status steps on the edge that shows the last cycle of a sub-loop
      sb = 3'(((k + 1) / (2 * NRC)) % 8);
      // Memory strobe toggles four times from 7 edges after a read, seen 2 edges later
      ds = rd && k >= NRCD && (((k - NRCD) % NRC) inside {9, 11});
      c = p == 0 ? 4'h3 : p == NRAS ? 4'h2 : rd && p == NRCD ? 4'h5 :
          p % 4 inside {1, 2} ? 4'h8 : 4'hF;
      `CHK("cmd", {c, b, sb, h ? 15'h0078 : 15'h0000, 1'b1, rd && p == NRCD},
           {cs_n, ras_n, cas_n, we_n, ba, sub, addr, busy, rd_issue})
      if (rd && p == NRCD) `CHK("data", h ? 8'h33 : 8'h00, exp_data)
      `CHK("dqs seen", ds, dqs_seen)
      `CHK("host pins", 11'h201, {dqs_out, dqs_oe_n, dq_out, dq_oe_n})
    end
    i_stop = 1;
    @(negedge i_sys_clk);
    i_stop = 0;
    @(negedge i_sys_clk);
    `CHK("stop", 5'h1E, {cs_n, ras_n, cas_n, we_n, busy})
    @(negedge i_sys_clk);
    $display("t_run %0d done", rd);
  endtask
  // Watchdog: two runs of about 200 cycles fit well inside 2000 cycles
  initial begin
    #200000;
    err_total++;
    end_of_test;
  end
  // Main sequence
  initial begin
    {i_nrst, i_start, i_stop, i_read_loop, i_mr0_bt, i_mr0_bl} = 0;
    i_ce = 1;
    i_nras = NRAS;
    i_nrc = NRC;
    i_nrcd = NRCD;
    repeat (12) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_nrst = 1;
    @(negedge i_sys_clk);
    `CHK("reset", {4'hF, 3'h0, 15'h0, 2'h0, 8'h00},
         {cs_n, ras_n, cas_n, we_n, ba, addr, busy, dm, exp_data})
    $display("t_reset done");
    t_cfg;
    t_run(0);
    t_run(1);
    end_of_test;
  end
endmodule
